// File: shared/ddc_cfg_pkg.sv
// types shared by the down-converter config register page
package ddc_cfg_pkg;
  typedef logic [15:0] addr_t;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] freq_word_t;
  typedef enum logic
  {
    BAND_SINGLE = 1'b0,
    BAND_DUAL = 1'b1
  } band_mode_t;
  typedef enum logic
  {
    FORMAT_COMPLEX = 1'b0,
    FORMAT_REAL = 1'b1
  } out_format_t;
  typedef enum logic
  {
    SOURCE_OWN = 1'b0,
    SOURCE_ALTERNATE = 1'b1
  } source_sel_t;
endpackage

// File: shared/ddc_cfg_regs.svh
// offsets, field positions, reset values of the down-converter config page
`ifndef DDC_CFG_REGS_SVH
`define DDC_CFG_REGS_SVH

// page bases, one per channel, 16-bit direct addressing
`define DDC_PAGE_BASE_A 16'h5000
`define DDC_PAGE_BASE_B 16'h5800
// offset field below the page base
`define DDC_PAGE_OFF_BITS 11

// register offsets within the page
`define DDC_OFF_BAND_MODE 11'h002
`define DDC_OFF_OUT_FORMAT 11'h005
`define DDC_OFF_SOURCE_SEL 11'h006
`define DDC_OFF_OSC_ONE_LOW 11'h007
`define DDC_OFF_OSC_ONE_HIGH 11'h008
`define DDC_OFF_OSC_TWO_LOW 11'h009
`define DDC_OFF_OSC_TWO_HIGH 11'h00a

// single mode bit position in the mode registers
`define DDC_MODE_BIT 0

// reset values
`define DDC_RST_MODE 1'h0
`define DDC_RST_BYTE 8'h00
`define DDC_RST_WORD 16'h0000

// frequency word resolution: one count is fs over 2 to this power
`define DDC_FREQ_WORD_BITS 16

`endif

// File: src/downconverter_config_regs.sv
// per-channel down-converter configuration register page
// Overview of operation
// - bit 0 at 002h picks single-band (0) or dual-band (1) filtering.
// - bit 0 at 005h picks complex (0) or real output at twice rate (1).
// - bit 0 at 006h makes the channel take samples from the alternate converter.
// - oscillator one frequency word: low byte 007h, high byte 008h.
// - oscillator two frequency word: low byte 009h, high byte 00Ah.
// - one count of a frequency word equals sampling rate over 2^16.
// - page directly addressed, 16-bit; base 5000h channel A, 5800h channel B.
module downconverter_config_regs
#(
  parameter bit CHANNEL_B = 1'b0
)
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire ddc_cfg_pkg::addr_t i_addr,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire ddc_cfg_pkg::byte_t i_wdata,
  output ddc_cfg_pkg::byte_t o_rdata,
  output logic o_rd_valid,
  output ddc_cfg_pkg::band_mode_t o_band_mode,
  output ddc_cfg_pkg::out_format_t o_out_format,
  output ddc_cfg_pkg::source_sel_t o_converter_source_swap,
  output ddc_cfg_pkg::freq_word_t o_osc_one_freq,
  output ddc_cfg_pkg::freq_word_t o_osc_two_freq
);
  import ddc_cfg_pkg::*;
  `include "ddc_cfg_regs.svh"

  localparam addr_t PAGE_BASE = CHANNEL_B ? `DDC_PAGE_BASE_B
                                          : `DDC_PAGE_BASE_A;

  logic page_hit;
  logic [`DDC_PAGE_OFF_BITS-1:0] page_off;
  logic wr_band;
  logic wr_format;
  logic wr_source;
  logic wr_one_low;
  logic wr_one_high;
  logic wr_two_low;
  logic wr_two_high;
  byte_t next_rdata;

  // only the page field is compared; the offset is the low 11 address bits
  function automatic logic in_page(input addr_t addr);
    in_page = addr[15:`DDC_PAGE_OFF_BITS] ==
              PAGE_BASE[15:`DDC_PAGE_OFF_BITS];
  endfunction

  function automatic logic wr_at(
    input logic [`DDC_PAGE_OFF_BITS-1:0] off,
    input logic [`DDC_PAGE_OFF_BITS-1:0] target);
    wr_at = i_wr_en && page_hit && (off == target);
  endfunction

  // mode registers expose one bit, the rest of the byte reads zero
  function automatic byte_t mode_byte(input logic bit_val);
    mode_byte = {7'h00, bit_val};
  endfunction

  assign page_hit = in_page(i_addr);
  assign page_off = i_addr[`DDC_PAGE_OFF_BITS-1:0];

  assign wr_band = wr_at(page_off, `DDC_OFF_BAND_MODE);
  assign wr_format = wr_at(page_off, `DDC_OFF_OUT_FORMAT);
  assign wr_source = wr_at(page_off, `DDC_OFF_SOURCE_SEL);
  assign wr_one_low = wr_at(page_off, `DDC_OFF_OSC_ONE_LOW);
  assign wr_one_high = wr_at(page_off, `DDC_OFF_OSC_ONE_HIGH);
  assign wr_two_low = wr_at(page_off, `DDC_OFF_OSC_TWO_LOW);
  assign wr_two_high = wr_at(page_off, `DDC_OFF_OSC_TWO_HIGH);

  // upper write bits are dropped, never stored
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_band_mode <= BAND_SINGLE;
    end
    else if (wr_band)
    begin
      o_band_mode <= band_mode_t'(i_wdata[`DDC_MODE_BIT]);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_out_format <= FORMAT_COMPLEX;
    end
    else if (wr_format)
    begin
      o_out_format <= out_format_t'(i_wdata[`DDC_MODE_BIT]);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_converter_source_swap <= SOURCE_OWN;
    end
    else if (wr_source)
    begin
      o_converter_source_swap <= source_sel_t'(i_wdata[`DDC_MODE_BIT]);
    end
  end

  // word counts fs / 2^16 per step, so width is the full 16 bits
  freq_word_pair osc_one
  (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_wr_low(wr_one_low),
    .i_wr_high(wr_one_high),
    .i_wdata(i_wdata),
    .o_word(o_osc_one_freq)
  );

  freq_word_pair osc_two
  (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_wr_low(wr_two_low),
    .i_wr_high(wr_two_high),
    .i_wdata(i_wdata),
    .o_word(o_osc_two_freq)
  );

  // unmapped offsets and other pages answer zero
  always_comb
  begin
    next_rdata = `DDC_RST_BYTE;
    if (page_hit)
    begin
      case (page_off)
        `DDC_OFF_BAND_MODE: next_rdata = mode_byte(o_band_mode);
        `DDC_OFF_OUT_FORMAT: next_rdata = mode_byte(o_out_format);
        `DDC_OFF_SOURCE_SEL:
          next_rdata = mode_byte(o_converter_source_swap);
        `DDC_OFF_OSC_ONE_LOW: next_rdata = o_osc_one_freq[7:0];
        `DDC_OFF_OSC_ONE_HIGH: next_rdata = o_osc_one_freq[15:8];
        `DDC_OFF_OSC_TWO_LOW: next_rdata = o_osc_two_freq[7:0];
        `DDC_OFF_OSC_TWO_HIGH: next_rdata = o_osc_two_freq[15:8];
        default: next_rdata = `DDC_RST_BYTE;
      endcase
    end
  end

  // read data held until the next read; a same-cycle write is not seen
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rdata <= `DDC_RST_BYTE;
    end
    else if (i_rd_en)
    begin
      o_rdata <= next_rdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd_en;
    end
  end

  localparam addr_t BAND_ADDR = PAGE_BASE | 16'(`DDC_OFF_BAND_MODE);

  property p_band_write;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_wr_en && i_addr == BAND_ADDR)
      |=> o_band_mode == $past(i_wdata[0]);
  endproperty
  a_band_write: assert property (p_band_write)
    else $error("band mode did not follow write");

  property p_format_write;
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_format |=> o_out_format == $past(i_wdata[0]);
  endproperty
  a_format_write: assert property (p_format_write)
    else $error("output format did not follow write");

  property p_source_hold;
    @(posedge i_clk) disable iff (!i_rst_b)
    !wr_source |=> $stable(o_converter_source_swap);
  endproperty
  a_source_hold: assert property (p_source_hold)
    else $error("source select changed without a write");

  property p_one_low_write;
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_one_low |=> o_osc_one_freq[7:0] == $past(i_wdata)
      && $stable(o_osc_one_freq[15:8]);
  endproperty
  a_one_low_write: assert property (p_one_low_write)
    else $error("oscillator one low byte write wrong");

  property p_two_high_write;
    @(posedge i_clk) disable iff (!i_rst_b)
    wr_two_high |=> o_osc_two_freq[15:8] == $past(i_wdata)
      && $stable(o_osc_two_freq[7:0]);
  endproperty
  a_two_high_write: assert property (p_two_high_write)
    else $error("oscillator two high byte write wrong");

  property p_word_hold;
    @(posedge i_clk) disable iff (!i_rst_b)
    !(wr_one_low || wr_one_high) [*2] |=> $stable(o_osc_one_freq);
  endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("frequency word moved without a write");

  property p_off_page;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_wr_en && !in_page(i_addr)) |=> $stable(o_band_mode)
      && $stable(o_osc_one_freq) && $stable(o_osc_two_freq);
  endproperty
  a_off_page: assert property (p_off_page)
    else $error("write outside the page changed state");

  property p_read_answer;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_rd_en && !in_page(i_addr)) |=> o_rd_valid && o_rdata == 8'h00;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("off-page read did not answer zero");

  property p_mode_upper_zero;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_rd_en && page_hit && page_off == `DDC_OFF_BAND_MODE)
      |=> o_rdata[7:1] == 7'h00 && o_rdata[0] == $past(o_band_mode);
  endproperty
  a_mode_upper_zero: assert property (p_mode_upper_zero)
    else $error("mode register upper bits not zero");

  property p_reset_zero;
    @(posedge i_clk)
    !i_rst_b |=> o_osc_one_freq == 16'h0000 && o_osc_two_freq == 16'h0000
      && o_band_mode == BAND_SINGLE && o_rdata == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("state not zero after reset");

  c_dual_band: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_band_mode));
  c_real_out: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_format && i_wdata[0]);
  c_full_word: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_one_low ##1 wr_one_high);
  c_read_back: cover property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_two_low ##1 (i_rd_en && page_off == `DDC_OFF_OSC_TWO_LOW));
endmodule

// File: src/freq_word_pair.sv
// one 16-bit oscillator frequency word held as low and high byte
module freq_word_pair
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_wr_low,
  input wire logic i_wr_high,
  input wire ddc_cfg_pkg::byte_t i_wdata,
  output ddc_cfg_pkg::freq_word_t o_word
);
  import ddc_cfg_pkg::*;
  `include "ddc_cfg_regs.svh"

  // bytes land independently; no shadow, so a half-written word is live
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_word <= `DDC_RST_WORD;
    end
    else
    begin
      if (i_wr_low)
      begin
        o_word[7:0] <= i_wdata;
      end
      if (i_wr_high)
      begin
        o_word[15:8] <= i_wdata;
      end
    end
  end
endmodule

// File: verification/downconverter_config_regs_bench.sv
// self-checking bench for the down-converter config register page
`include "ddc_cfg_regs.svh"
`define CHK(g, e) compare(16'(g), 16'(e))
module downconverter_config_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import ddc_cfg_pkg::*;
  localparam addr_t base = `DDC_PAGE_BASE_A;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  addr_t i_addr = 16'h0000;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  byte_t i_wdata = 8'h00;
  byte_t o_rdata;
  logic o_rd_valid;
  band_mode_t o_band_mode;
  out_format_t o_out_format;
  source_sel_t o_converter_source_swap;
  freq_word_t o_osc_one_freq;
  freq_word_t o_osc_two_freq;
  band_mode_t b_band_mode;
  freq_word_t b_osc_one_freq;
  int miscompares = 0;
  int checks = 0;
  logic [10:0] mode_off [3] = '{`DDC_OFF_BAND_MODE, `DDC_OFF_OUT_FORMAT,
    `DDC_OFF_SOURCE_SEL};

  downconverter_config_regs #(.CHANNEL_B(1'b0)) dut
  (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_addr(i_addr),
    .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en),
    .i_wdata(i_wdata),
    .o_rdata(o_rdata),
    .o_rd_valid(o_rd_valid),
    .o_band_mode(o_band_mode),
    .o_out_format(o_out_format),
    .o_converter_source_swap(o_converter_source_swap),
    .o_osc_one_freq(o_osc_one_freq),
    .o_osc_two_freq(o_osc_two_freq)
  );

  // second page on the same strobes: channel B base must decode
  downconverter_config_regs #(.CHANNEL_B(1'b1)) dut_b
  (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_addr(i_addr),
    .i_wr_en(i_wr_en),
    .i_rd_en(i_rd_en),
    .i_wdata(i_wdata),
    .o_rdata(),
    .o_rd_valid(),
    .o_band_mode(b_band_mode),
    .o_out_format(),
    .o_converter_source_swap(),
    .o_osc_one_freq(b_osc_one_freq),
    .o_osc_two_freq()
  );

  always #50 i_clk = ~i_clk;

  task automatic end_sim();
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic compare(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  function automatic logic mode_out(input int i);
    case (i)
      0: return o_band_mode;
      1: return o_out_format;
      default: return o_converter_source_swap;
    endcase
  endfunction

  // outputs sampled at the falling edge, well clear of the update
  task automatic wr(input addr_t a, input byte_t d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr_en <= 1'b1;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
    @(negedge i_clk);
  endtask

  task automatic rd(input addr_t a, input byte_t e);
    int n;
    @(posedge i_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_clk);
    i_rd_en <= 1'b0;
    n = 0;
    do
    begin
      @(negedge i_clk);
      n++;
    end
    while (o_rd_valid !== 1'b1 && n < 4);
    if (o_rd_valid !== 1'b1)
    begin
      miscompares++;
      end_sim();
    end
    `CHK(o_rdata, e);
    @(negedge i_clk);
    `CHK(o_rd_valid, 1'b0);
  endtask

  initial
  begin
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (int i = 0; i < 11; i++)
      rd(base + addr_t'(i), 8'h00);
    // upper bits written as ones must not leak into readback
    for (int i = 0; i < 3; i++)
    begin
      wr(base + 16'(mode_off[i]), 8'hff);
      for (int j = 0; j < 3; j++)
        `CHK(mode_out(j), j == i);
      rd(base + 16'(mode_off[i]), 8'h01);
      wr(base + 16'(mode_off[i]), 8'hfe);
      `CHK(mode_out(i), 1'b0);
      rd(base + 16'(mode_off[i]), 8'h00);
    end
    wr(base + 16'h0007, 8'h34);
    `CHK(o_osc_one_freq, 16'h0034);
    wr(base + 16'h0008, 8'h12);
    `CHK(o_osc_one_freq, 16'h1234);
    wr(base + 16'h000a, 8'hab);
    `CHK(o_osc_two_freq, 16'hab00);
    wr(base + 16'h0009, 8'hcd);
    `CHK(o_osc_two_freq, 16'habcd);
    `CHK(o_osc_one_freq, 16'h1234);
    rd(base + 16'h0007, 8'h34);
    rd(base + 16'h0008, 8'h12);
    rd(base + 16'h0009, 8'hcd);
    rd(base + 16'h000a, 8'hab);
    wr(base + 16'h0007, 8'hff);
    wr(base + 16'h0008, 8'hff);
    `CHK(o_osc_one_freq, 16'hffff);
    // other channel's page and neighbouring pages must not alias
    wr(`DDC_PAGE_BASE_B + 16'h0007, 8'h55);
    wr(16'h4807, 8'h66);
    `CHK(o_osc_one_freq, 16'hffff);
    `CHK(b_osc_one_freq, 16'h0055);
    rd(`DDC_PAGE_BASE_B + 16'h0007, 8'h00);
    rd(16'h4807, 8'h00);
    wr(`DDC_PAGE_BASE_B + 16'h0002, 8'h01);
    `CHK(o_band_mode, BAND_SINGLE);
    `CHK(b_band_mode, BAND_DUAL);
    wr(base + 16'h0003, 8'h77);
    rd(base + 16'h0003, 8'h00);
    wr(base + 16'h0006, 8'h01);
    `CHK(o_converter_source_swap, SOURCE_ALTERNATE);
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    @(negedge i_clk);
    `CHK(o_osc_one_freq, 16'h0000);
    `CHK(o_osc_two_freq, 16'h0000);
    `CHK(o_converter_source_swap, SOURCE_OWN);
    `CHK(b_osc_one_freq, 16'h0000);
    `CHK(b_band_mode, BAND_SINGLE);
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(base + 16'h000a, 8'h00);
    end_sim();
  end
endmodule
